// file: rtl/serial_adc_sequencer.sv
// main sequencer and link-side shift engine for a serial 8-channel converter
//
// Behaviour
// - edge select pin held at 1 so converter samples on rising serial clock.
// - serial data in changes only while serial clock is low.
// - register-mode first byte carries address, read/write and 8/16-bit width.
// - eight or sixteen data bits follow the register instruction byte; the sequencer always sends eight.
// - port active only with chip select low; converter counts clock edges.
// - chip select goes high after every complete command.
// - one direct-mode byte selects channel and gain and starts conversion.
// - all selected registers written, address then data, before conversion.
// - same direct byte repeats per sample; new channel gets new byte.
// - after a channel's samples, move to next enabled channel until done.
// - each received result becomes one 16-bit memory word write.
// - sequencer loads the byte and toggles shift start in the same cycle.
// - direction 0 sends exactly 8 bits.
// - direction 1 receives 16 bits: result, three zeros, overflow.
// - sequencer waits for shift finished before its next step.
// - pending-write flag per register cleared when addressed.
`timescale 1ns/1ps
module serial_adc_sequencer
  import serial_adc_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic cclk,
  input wire logic start,
  input wire reg_init_t [N_INIT-1:0] init_list,
  input wire logic [N_CHAN-1:0] chan_enable,
  input wire logic [2:0] gain,
  input wire logic [7:0] sample_count,
  input wire logic adc_serial_out,
  output logic adc_serial_in,
  output logic serial_bit_clock,
  output logic chip_select_n,
  output logic edge_select,
  output logic mem_wr,
  output mem_write_t mem_w,
  output logic busy,
  output logic done
);
  // ==========================================================
  // main domain signals
  main_state_t state;
  logic [N_INIT-1:0] pend;
  logic [1:0] wr_idx;
  logic [2:0] chan;
  logic [7:0] sample_idx;
  shift_req_t req;
  logic start_tgl;
  logic fin_m1, fin_m2, fin_m3;
  logic fin_evt;
  // link domain signals
  logic lrst_1, link_rst_n;
  logic st_l1, st_l2, st_l3;
  logic start_evt;
  logic dout_1, dout_2;
  logic active;
  logic [5:0] hc, next_hc, end_hc;
  logic [1:0] gap;
  logic [7:0] tx_sh;
  logic [15:0] rx_sh, rx_word;
  logic fin_tgl;
  shift_req_t cur;
  function automatic logic [3:0] pick_chan(input logic [N_CHAN-1:0] en,
      input logic [2:0] from, input logic incl);
    logic [3:0] r;
    r = 4'h0;
    for (int i = N_CHAN - 1; i >= 0; i--) begin
      if (en[i] && (i > int'(from) || (incl && i == int'(from)))) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction
  function automatic logic [1:0] first_pend(input logic [N_INIT-1:0] p);
    logic [1:0] r;
    r = 2'h0;
    for (int i = N_INIT - 1; i >= 0; i--) begin
      if (p[i]) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction
  function automatic logic [7:0] reg_instr(input logic [RM_ADDR_W-1:0] a);
    logic [7:0] b;
    b = 8'h00;
    b[RM_MODE_BIT] = 1'b0;
    b[RM_READ_BIT] = 1'b0;
    b[RM_WIDE_BIT] = 1'b0;
    b[RM_ADDR_LSB +: RM_ADDR_W] = a;
    return b;
  endfunction
  function automatic logic [7:0] dm_instr(input logic [2:0] g, input logic [2:0] c);
    logic [7:0] b;
    b = 8'h00;
    b[DM_MODE_BIT] = 1'b1;
    b[DM_GAIN_LSB +: 3] = g;
    b[DM_SE_BIT] = DM_SINGLE_ENDED;
    b[DM_CHAN_LSB +: 3] = c;
    return b;
  endfunction
  logic [3:0] first_chan, after_chan;
  logic [N_INIT-1:0] init_en;
  always_comb begin
    first_chan = pick_chan(chan_enable, 3'h0, 1'b1);
    after_chan = pick_chan(chan_enable, chan, 1'b0);
    for (int i = 0; i < N_INIT; i++) begin
      init_en[i] = init_list[i].en;
    end
  end
  // ==========================================================
  // edge select pin
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      edge_select <= EDGE_SEL_RISE;
    end else begin
      edge_select <= EDGE_SEL_RISE;
    end
  end
  // ==========================================================
  // finished handshake back from the link
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      {fin_m3, fin_m2, fin_m1} <= 3'h0;
    end else begin
      {fin_m3, fin_m2, fin_m1} <= {fin_m2, fin_m1, fin_tgl};
    end
  end
  assign fin_evt = fin_m2 ^ fin_m3;
  // ==========================================================
  // main sequencer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      pend <= '0;
      wr_idx <= 2'h0;
      chan <= 3'h0;
      sample_idx <= 8'h00;
      req <= '0;
      start_tgl <= 1'b0;
      mem_wr <= 1'b0;
      mem_w <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      mem_wr <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (start) begin
            busy <= 1'b1;
            done <= 1'b0;
            pend <= init_en;
            chan <= first_chan[2:0];
            sample_idx <= 8'h00;
            if (|init_en) begin
              state <= ST_WR_ADDR;
            end else if (first_chan[3]) begin
              state <= ST_DIRECT;
            end else begin
              state <= ST_DONE;
            end
          end
        end
        ST_WR_ADDR: begin
          wr_idx <= first_pend(pend);
          pend[first_pend(pend)] <= 1'b0;
          req.data <= reg_instr(init_list[first_pend(pend)].addr);
          req.dir <= DIR_TX;
          req.hold <= 1'b1;
          start_tgl <= ~start_tgl;
          state <= ST_WAIT_ADDR;
        end
        ST_WAIT_ADDR: begin
          if (fin_evt) begin
            state <= ST_WR_DATA;
          end
        end
        ST_WR_DATA: begin
          req.data <= init_list[wr_idx].data;
          req.dir <= DIR_TX;
          req.hold <= 1'b0;
          start_tgl <= ~start_tgl;
          state <= ST_WAIT_DATA;
        end
        ST_WAIT_DATA: begin
          if (fin_evt) begin
            if (|pend) begin
              state <= ST_WR_ADDR;
            end else if (first_chan[3]) begin
              state <= ST_DIRECT;
            end else begin
              state <= ST_DONE;
            end
          end
        end
        ST_DIRECT: begin
          req.data <= dm_instr(gain, chan);
          req.dir <= DIR_TX;
          req.hold <= 1'b1;
          start_tgl <= ~start_tgl;
          state <= ST_WAIT_DM;
        end
        ST_WAIT_DM: begin
          if (fin_evt) begin
            state <= ST_ASSIGN;
          end
        end
        ST_ASSIGN: begin
          req.dir <= DIR_RX;
          req.hold <= 1'b0;
          start_tgl <= ~start_tgl;
          state <= ST_READ;
        end
        ST_READ: begin
          if (fin_evt) begin
            mem_wr <= 1'b1;
            mem_w.data <= rx_word;
            mem_w.addr <= {chan, sample_idx};
            if (sample_idx != sample_count - 8'h01) begin
              sample_idx <= sample_idx + 8'h01;
              state <= ST_DIRECT;
            end else if (after_chan[3]) begin
              chan <= after_chan[2:0];
              sample_idx <= 8'h00;
              state <= ST_DIRECT;
            end else begin
              state <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          busy <= 1'b0;
          done <= 1'b1;
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  // ==========================================================
  // link domain: reset release and input synchronisers
  always_ff @(posedge cclk or negedge arst_n) begin
    if (!arst_n) begin
      {link_rst_n, lrst_1} <= 2'b00;
    end else begin
      {link_rst_n, lrst_1} <= {lrst_1, 1'b1};
    end
  end
  always_ff @(posedge cclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      {st_l3, st_l2, st_l1} <= 3'h0;
      {dout_2, dout_1} <= 2'b00;
    end else begin
      {st_l3, st_l2, st_l1} <= {st_l2, st_l1, start_tgl};
      {dout_2, dout_1} <= {dout_1, adc_serial_out};
    end
  end
  assign start_evt = st_l2 ^ st_l3;
  // ==========================================================
  // shift engine
  // req has stood still for two link edges when the start toggle lands;
  // it is copied then, since the sequencer reloads it while a held frame waits
  always_comb begin
    next_hc = hc + 6'h01;
    end_hc = (cur.dir == DIR_RX) ? RX_END_HC : TX_END_HC;
  end
  always_ff @(posedge cclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      active <= 1'b0;
      hc <= 6'h00;
      gap <= 2'h0;
      tx_sh <= 8'h00;
      rx_sh <= 16'h0000;
      rx_word <= 16'h0000;
      fin_tgl <= 1'b0;
      cur <= '0;
      chip_select_n <= CS_IDLE;
      serial_bit_clock <= 1'b0;
      adc_serial_in <= 1'b0;
    end else begin
      if (start_evt && !active) begin
        active <= 1'b1;
        chip_select_n <= 1'b0;
        hc <= 6'h00;
        serial_bit_clock <= 1'b0;
        tx_sh <= req.data;
        cur <= req;
        adc_serial_in <= (req.dir == DIR_TX) ? req.data[7] : 1'b0;
      end else if (active) begin
        hc <= next_hc;
        // rising at odd counts only; the trailing counts of a read
        // leave the clock low while the synchroniser catches up
        if (cur.dir == DIR_RX) begin
          serial_bit_clock <= next_hc[0] && next_hc < 6'(RX_BITS * SCLK_DIV);
        end else begin
          serial_bit_clock <= next_hc[0] && next_hc < TX_END_HC;
        end
        if (cur.dir == DIR_TX && !next_hc[0] && next_hc < TX_END_HC) begin
          tx_sh <= {tx_sh[6:0], 1'b0};
          adc_serial_in <= tx_sh[6];
        end
        if (cur.dir == DIR_RX && !next_hc[0] && next_hc >= RX_FIRST_HC) begin
          rx_sh <= {rx_sh[14:0], dout_2};
        end
        if (next_hc == end_hc) begin
          active <= 1'b0;
          rx_word <= {rx_sh[14:0], dout_2};
          if (cur.hold) begin
            fin_tgl <= ~fin_tgl;
          end else begin
            chip_select_n <= 1'b1;
            gap <= CS_GAP;
          end
        end
      end else if (gap != 2'h0) begin
        gap <= gap - 2'h1;
        if (gap == 2'h1) begin
          fin_tgl <= ~fin_tgl;
        end
      end
    end
  end
  // ==========================================================
  // checks
  logic [4:0] rise_cnt;
  logic sclk_d;
  always_ff @(posedge cclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rise_cnt <= 5'h00;
      sclk_d <= 1'b0;
    end else begin
      sclk_d <= serial_bit_clock;
      if (start_evt && !active) begin
        rise_cnt <= 5'h00;
      end else if (serial_bit_clock && !sclk_d) begin
        rise_cnt <= rise_cnt + 5'h01;
      end
    end
  end

  property p_edge_sel;
    @(posedge mclk) disable iff (!arst_n) 1'b1 |=> edge_select;
  endproperty
  a_edge_sel: assert property (p_edge_sel) else $error("edge select not high");
  property p_din_stable;
    @(posedge cclk) disable iff (!link_rst_n) serial_bit_clock |-> $stable(adc_serial_in);
  endproperty
  a_din_stable: assert property (p_din_stable) else $error("din moved with clock high");
  property p_clk_in_frame;
    @(posedge cclk) disable iff (!link_rst_n) serial_bit_clock |-> !chip_select_n;
  endproperty
  a_clk_in_frame: assert property (p_clk_in_frame) else $error("clock outside frame");
  // frame kind comes from the link copy, the sequencer may already hold the next one
  property p_cs_release;
    @(posedge cclk) disable iff (!link_rst_n) ($fell(active) && !cur.hold) |-> chip_select_n;
  endproperty
  a_cs_release: assert property (p_cs_release) else $error("select not raised");
  property p_cs_gap;
    @(posedge cclk) disable iff (!link_rst_n) $rose(chip_select_n) |=> chip_select_n;
  endproperty
  a_cs_gap: assert property (p_cs_gap) else $error("select high too briefly");
  property p_tx_bits;
    @(posedge cclk) disable iff (!link_rst_n)
      ($fell(active) && cur.dir == DIR_TX) |-> rise_cnt == 5'h08;
  endproperty
  a_tx_bits: assert property (p_tx_bits) else $error("send byte not 8 clocks");
  property p_rx_bits;
    @(posedge cclk) disable iff (!link_rst_n)
      ($fell(active) && cur.dir == DIR_RX) |-> rise_cnt == 5'h10;
  endproperty
  a_rx_bits: assert property (p_rx_bits) else $error("read not 16 clocks");
  property p_wait_fin;
    @(posedge mclk) disable iff (!arst_n)
      (state == ST_WAIT_DM && !fin_evt) |=> state == ST_WAIT_DM;
  endproperty
  a_wait_fin: assert property (p_wait_fin) else $error("left wait early");
  property p_pend_clear;
    @(posedge mclk) disable iff (!arst_n) state == ST_WR_ADDR |=> !pend[wr_idx];
  endproperty
  a_pend_clear: assert property (p_pend_clear) else $error("pending flag kept");
  property p_init_first;
    @(posedge mclk) disable iff (!arst_n) state == ST_DIRECT |-> pend == '0;
  endproperty
  a_init_first: assert property (p_init_first) else $error("convert before init");
  property p_load_start;
    @(posedge mclk) disable iff (!arst_n)
      state == ST_DIRECT |=> req.data[DM_MODE_BIT] && $changed(start_tgl);
  endproperty
  a_load_start: assert property (p_load_start) else $error("direct byte not issued");
  property p_mem_word;
    @(posedge mclk) disable iff (!arst_n)
      (state == ST_READ && fin_evt) |=> mem_wr && mem_w.data == rx_word;
  endproperty
  a_mem_word: assert property (p_mem_word) else $error("result not written");
endmodule // serial_adc_sequencer

// file: rtl/serial_adc_pkg.sv
// shared constants and carrier types for the serial converter sequencer
package serial_adc_pkg;
  // ==========================================================
  // sizes
  localparam int N_INIT = 4;
  localparam int N_CHAN = 8;
  localparam int TX_BITS = 8;
  localparam int RX_BITS = 16;
  // ==========================================================
  // link timing, in link clock edges
  localparam int SCLK_DIV = 2;
  localparam int SYNC_LAG = 2;
  localparam logic [5:0] TX_END_HC = 6'(TX_BITS * SCLK_DIV);
  localparam logic [5:0] RX_END_HC = 6'(RX_BITS * SCLK_DIV + SYNC_LAG);
  localparam logic [5:0] RX_FIRST_HC = 6'(SCLK_DIV + SYNC_LAG);
  localparam logic [1:0] CS_GAP = 2'(SCLK_DIV);
  // ==========================================================
  // instruction byte layout
  localparam int RM_MODE_BIT = 7;
  localparam int RM_READ_BIT = 6;
  localparam int RM_WIDE_BIT = 5;
  localparam int RM_ADDR_LSB = 0;
  localparam int RM_ADDR_W = 5;
  localparam int DM_MODE_BIT = 7;
  localparam int DM_GAIN_LSB = 4;
  localparam int DM_SE_BIT = 3;
  localparam int DM_CHAN_LSB = 0;
  // ==========================================================
  // pin and field values
  localparam logic EDGE_SEL_RISE = 1'b1;
  localparam logic CS_IDLE = 1'b1;
  localparam logic DIR_TX = 1'b0;
  localparam logic DIR_RX = 1'b1;
  localparam logic DM_SINGLE_ENDED = 1'b1;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic en;
    logic [RM_ADDR_W-1:0] addr;
    logic [7:0] data;
  } reg_init_t;
  typedef struct packed {
    logic [7:0] data;
    logic dir;
    logic hold;
  } shift_req_t;
  typedef struct packed {
    logic [10:0] addr;
    logic [15:0] data;
  } mem_write_t;
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_WR_ADDR = 10'h002,
    ST_WAIT_ADDR = 10'h004,
    ST_WR_DATA = 10'h008,
    ST_WAIT_DATA = 10'h010,
    ST_DIRECT = 10'h020,
    ST_WAIT_DM = 10'h040,
    ST_ASSIGN = 10'h080,
    ST_READ = 10'h100,
    ST_DONE = 10'h200
  } main_state_t;
endpackage

// file: bench/adc_model.sv
// behavioural model of the serial converter at the far end of the link
`timescale 1ns/1ps
module adc_model (
  input wire logic serial_bit_clock,
  input wire logic chip_select_n,
  input wire logic adc_serial_in,
  input wire logic edge_select,
  output logic adc_serial_out,
  output int faults
);
  // ==========================================================
  // frame state
  logic [23:0] sr = '0;
  logic [15:0] result = '0;
  logic direct = 1'b0;
  logic fell = 1'b0;
  int rises = 0;
  int conv_cnt = 0;
  realtime cs_hi_t = 0.0;
  realtime clk_hi_t = 0.0;
  realtime din_t = 0.0;
  logic [13:0] log_q [$];
  initial begin
    faults = 0;
    adc_serial_out = 1'b0;
  end
  task automatic flag(input string msg);
    faults++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask
  // ==========================================================
  // select edges
  always @(negedge chip_select_n) begin
    if ($realtime - cs_hi_t < 249.0) flag("select high too short");
    rises = 0;
    direct = 1'b0;
    fell = 1'b1;
  end
  always @(posedge chip_select_n) begin
    if (fell && rises != (direct ? 24 : 16)) flag("frame length");
    cs_hi_t = $realtime;
    // released line: inverse of last value, no pull on it
    adc_serial_out = ~adc_serial_out;
  end
  // ==========================================================
  // serial clock
  always @(adc_serial_in) din_t = $realtime;
  always @(negedge serial_bit_clock) begin
    if (!chip_select_n && din_t >= clk_hi_t && din_t < $realtime) flag("data moved in high phase");
  end
  always @(posedge serial_bit_clock) begin
    clk_hi_t = $realtime;
    if (chip_select_n !== 1'b0) flag("clock outside frame");
    if (edge_select !== 1'b1) flag("edge select low");
    sr = {sr[22:0], adc_serial_in};
    rises++;
    if (rises == 8 && sr[7]) begin
      direct = 1'b1;
      // two's complement value, three zeros, overflow bit
      result = {sr[2:0], sr[6:4], 6'(conv_cnt), 3'b000, conv_cnt[0]};
      conv_cnt++;
      log_q.push_back({1'b1, 5'h00, sr[7:0]});
    end
    if (rises == 16 && !direct) begin
      if (sr[14] || sr[13]) flag("unsupported register access");
      log_q.push_back({1'b0, sr[12:0]});
    end
    if (direct && rises > 8 && rises <= 24) #1 adc_serial_out = result[24 - rises];
  end
endmodule // adc_model

// file: bench/tb.sv
// self-checking bench for the serial converter sequencer
`timescale 1ns/1ps
module tb;
  import serial_adc_pkg::*;
  logic mclk, cclk, arst_n, start;
  reg_init_t [N_INIT-1:0] init_list;
  logic [N_CHAN-1:0] chan_enable;
  logic [2:0] gain;
  logic [7:0] sample_count;
  logic adc_serial_out, adc_serial_in, serial_bit_clock, chip_select_n, edge_select;
  logic mem_wr, busy, done;
  mem_write_t mem_w;
  int faults, miscompares, tests_run, conv_cnt, seed_dummy;
  mem_write_t exp_mem [$];
  logic [13:0] exp_log [$];
  // ==========================================================
  // design and converter
  serial_adc_sequencer uut (
    .mclk(mclk), .arst_n(arst_n), .cclk(cclk), .start(start), .init_list(init_list),
    .chan_enable(chan_enable), .gain(gain), .sample_count(sample_count),
    .adc_serial_out(adc_serial_out), .adc_serial_in(adc_serial_in),
    .serial_bit_clock(serial_bit_clock), .chip_select_n(chip_select_n),
    .edge_select(edge_select), .mem_wr(mem_wr), .mem_w(mem_w), .busy(busy), .done(done)
  );
  adc_model adc (
    .serial_bit_clock(serial_bit_clock), .chip_select_n(chip_select_n),
    .adc_serial_in(adc_serial_in), .edge_select(edge_select),
    .adc_serial_out(adc_serial_out), .faults(faults)
  );
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // link clock offset so its edges never line up with mclk
  // first rising edge lands inside reset, so the link side is cleared too
  initial begin
    cclk = 1'b0;
    #41.3;
    forever begin
      cclk = ~cclk;
      #62.5;
    end
  end
  // ==========================================================
  // checking
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic wrap_up;
    miscompares += faults;
    if (miscompares == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // looked at mid-cycle, where the write pulse and its word have settled
  always @(negedge mclk) begin
    if (mem_wr === 1'b1) begin
      if (exp_mem.size() == 0) check(1'b0, "extra memory write");
      else check(mem_w === exp_mem.pop_front(), "memory word");
    end
  end
  // ==========================================================
  // one run: expectations first, then start and wait
  task automatic run(input logic again);
    int n;
    int k;
    n = (sample_count == 8'h00) ? 256 : int'(sample_count);
    for (int i = 0; i < N_INIT; i++) begin
      if (init_list[i].en) exp_log.push_back({1'b0, init_list[i].addr, init_list[i].data});
    end
    for (int c = 0; c < N_CHAN; c++) begin
      if (chan_enable[c]) begin
        for (int i = 0; i < n; i++) begin
          exp_log.push_back({1'b1, 5'h00, 1'b1, gain, DM_SINGLE_ENDED, 3'(c)});
          exp_mem.push_back({3'(c), 8'(i), 3'(c), gain, 6'(conv_cnt), 3'b000, conv_cnt[0]});
          conv_cnt++;
        end
      end
    end
    start = 1'b1;
    @(negedge mclk) start = 1'b0;
    repeat (2) @(negedge mclk);
    if (again) begin
      check(busy === 1'b1 && done === 1'b0, "not busy after start");
      // a start while busy must change nothing
      repeat (300) @(negedge mclk);
      start = 1'b1;
      @(negedge mclk) start = 1'b0;
    end
    k = 0;
    while (done !== 1'b1 && k < 60000) begin
      @(negedge mclk);
      k++;
    end
    repeat (4) @(negedge mclk);
    check(done === 1'b1 && busy === 1'b0 && chip_select_n === CS_IDLE, "run end");
    check(exp_mem.size() == 0, "missing memory writes");
    check(adc.log_q.size() == exp_log.size(), "command count");
    while (exp_log.size() > 0 && adc.log_q.size() > 0) begin
      check(adc.log_q.pop_front() === exp_log.pop_front(), "command byte");
    end
    exp_log.delete();
    adc.log_q.delete();
  endtask
  // ==========================================================
  // main sequence
  initial begin
    arst_n = 1'b0;
    start = 1'b0;
    init_list = '0;
    chan_enable = '0;
    gain = 3'h0;
    sample_count = 8'h01;
    miscompares = 0;
    tests_run = 0;
    conv_cnt = 0;
    repeat (12) @(negedge mclk);
    check(chip_select_n === CS_IDLE && serial_bit_clock === 1'b0 && busy === 1'b0
      && done === 1'b0 && mem_wr === 1'b0, "reset state");
    arst_n = 1'b1;
    repeat (40) @(negedge mclk);
    check(edge_select === EDGE_SEL_RISE && chip_select_n === CS_IDLE, "idle pins");
    seed_dummy = $urandom(32'hFF8570DB);
    // boundary channels, every init entry
    for (int i = 0; i < N_INIT; i++) init_list[i] = {1'b1, 5'($urandom), 8'($urandom)};
    chan_enable = 8'h81;
    gain = 3'h7;
    sample_count = 8'h02;
    run(1'b1);
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < N_INIT; i++) init_list[i] = {1'($urandom), 5'($urandom), 8'($urandom)};
      chan_enable = 8'($urandom);
      gain = 3'($urandom);
      sample_count = 8'(1 + $urandom % 2);
      run(1'b0);
    end
    init_list = '0;
    chan_enable = 8'h00;
    run(1'b0);
    wrap_up();
  end
  initial begin
    repeat (100000) @(posedge mclk);
    check(1'b0, "timeout");
    wrap_up();
  end
endmodule // tb
